// ### common/dvr_pkg.sv
`default_nettype none

package dvr_pkg;

    // ************************************************************
    // Register indices of the bank
    // ************************************************************
    localparam logic [15:0] IDX_UPPER = 16'h0001;
    localparam logic [15:0] IDX_LOWER = 16'h0002;
    localparam logic [15:0] IDX_FORMAT = 16'h0003;
    localparam logic [15:0] IDX_SHIFT = 16'h0004;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [31:0] VALUE_RESET = 32'h0000_0000;

    // ************************************************************
    // Holding register functions and group limit
    // ************************************************************
    localparam logic [7:0] FN_READ = 8'h03;
    localparam logic [7:0] FN_WRITE_ONE = 8'h06;
    localparam logic [7:0] FN_WRITE_MANY = 8'h10;
    localparam logic [7:0] GROUP_MIN = 8'h01;
    localparam logic [7:0] GROUP_MAX = 8'h10;

    // ************************************************************
    // Format control fields
    // ************************************************************
    localparam logic [7:0] MODE_DIGITS = 8'h00;
    localparam logic [7:0] MODE_HIGH = 8'h80;
    localparam logic [7:0] MODE_LOW = 8'h40;
    localparam int MODE_HI = 15;
    localparam int MODE_LO = 8;
    localparam int MINDIG_HI = 6;
    localparam int MINDIG_LO = 4;
    localparam int DP_RIGHT_BIT = 3;
    localparam int DP_HI = 2;
    localparam int DP_LO = 0;
    localparam int SHIFT_HI = 3;
    localparam int SHIFT_LO = 0;

    // ************************************************************
    // Displayable range
    // ************************************************************
    localparam logic signed [32:0] RANGE_MAX = 33'sd9999;
    localparam logic signed [32:0] RANGE_MIN = -33'sd999;

    typedef enum logic [1:0] {
        TYPE_U16 = 2'h0,
        TYPE_S16 = 2'h1,
        TYPE_U32 = 2'h2,
        TYPE_S32 = 2'h3
    } dvr_type_e;

endpackage : dvr_pkg

`default_nettype wire

// ### src/dvr_display_value_register_bank.sv
// Overview of operation
// - Upper value word held at index 01h
// - Lower value word held at index 02h
// - Upper write alone leaves display unchanged
// - Valid display range is -999 to 9999
// - Mode 00h: digits with over-range warnings
// - Mode 80h: show fixed high message
// - Mode 40h: show fixed low message
// - Bits 6..4: minimum digits minus one
// - Min digits output for leading-zero padding
// - Bit 3 forces rightmost decimal point
// - Bits 2..0: digits after decimal point
// - Index 04h bits 3..0: left shift
// - Type picks 16/32-bit, signed or unsigned
// - Read 03h, write 06h/10h, max 16
// - Write lock spares value and mode registers
// - Reply suppression after value or mode writes
`timescale 1ns/1ps
`default_nettype none

module dvr_display_value_register_bank (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic acc_valid_i,
    input wire logic [7:0] acc_func_i,
    input wire logic [15:0] acc_idx_i,
    input wire logic [7:0] acc_qty_i,
    input wire logic [15:0] acc_data_i,
    input wire logic acc_broadcast_i,
    input wire dvr_pkg::dvr_type_e value_type_i,
    input wire logic config_write_lock_i,
    input wire logic reply_after_value_write_i,
    output logic [15:0] rd_data_o,
    output logic rd_ack_o,
    output logic wr_ack_o,
    output logic reject_o,
    output logic reply_o,
    output logic [31:0] shown_value_o,
    output logic over_range_high_warning_o,
    output logic over_range_low_warning_o,
    output logic fixed_high_message_o,
    output logic fixed_low_message_o,
    output logic [2:0] min_digits_o,
    output logic dp_rightmost_o,
    output logic [2:0] dp_places_o,
    output logic [3:0] left_shift_o
);
    import dvr_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    logic [15:0] upper_r, upper_nxt;
    logic [15:0] lower_r, lower_nxt;
    logic [15:0] format_r, format_nxt;
    logic [15:0] shift_r, shift_nxt;
    logic [31:0] shown_r, shown_nxt;
    logic [15:0] rd_data_r, rd_data_nxt;
    logic rd_ack_r, rd_ack_nxt;
    logic wr_ack_r, wr_ack_nxt;
    logic reject_r, reject_nxt;
    logic reply_r, reply_nxt;
    logic ovh_r, ovh_nxt;
    logic ovl_r, ovl_nxt;
    logic fhm_r, fhm_nxt;
    logic flm_r, flm_nxt;

    logic is_read, is_write, qty_ok, in_bank, value_reg, wr_go, rd_go, chk_high, chk_low;
    logic [7:0] mode;

    dvr_range_check u_range (
        .value_i(shown_r),
        .type_i(value_type_i),
        .over_high_o(chk_high),
        .over_low_o(chk_low)
    );

    // ************************************************************
    // Access decode and next state
    // ************************************************************
    always_comb begin
        is_read = acc_func_i == FN_READ;
        is_write = (acc_func_i == FN_WRITE_ONE) || (acc_func_i == FN_WRITE_MANY);
        qty_ok = (acc_qty_i >= GROUP_MIN) && (acc_qty_i <= GROUP_MAX);
        in_bank = (acc_idx_i >= IDX_UPPER) && (acc_idx_i <= IDX_SHIFT);
        value_reg = (acc_idx_i >= IDX_UPPER) && (acc_idx_i <= IDX_FORMAT);
        // Lock guards configuration only, never this bank
        wr_go = acc_valid_i && is_write && qty_ok && in_bank;
        rd_go = acc_valid_i && is_read && qty_ok && in_bank;
        mode = format_r[MODE_HI:MODE_LO];

        upper_nxt = upper_r;
        lower_nxt = lower_r;
        format_nxt = format_r;
        shift_nxt = shift_r;
        shown_nxt = shown_r;
        if (wr_go) begin
            unique case (acc_idx_i)
                IDX_UPPER: upper_nxt = acc_data_i;
                IDX_LOWER: begin
                    lower_nxt = acc_data_i;
                    // Staged upper joins new lower in one edge
                    shown_nxt = {upper_r, acc_data_i};
                end
                IDX_FORMAT: format_nxt = acc_data_i;
                default: shift_nxt = acc_data_i;
            endcase
        end

        rd_ack_nxt = rd_go;
        unique case (acc_idx_i)
            IDX_UPPER: rd_data_nxt = upper_r;
            IDX_LOWER: rd_data_nxt = lower_r;
            IDX_FORMAT: rd_data_nxt = format_r;
            IDX_SHIFT: rd_data_nxt = shift_r;
            default: rd_data_nxt = REG_RESET;
        endcase
        if (!rd_go) begin
            rd_data_nxt = rd_data_r;
        end

        wr_ack_nxt = wr_go;
        // Foreign-index writes under lock are refused here for the whole device; foreign reads are not
        reject_nxt = acc_valid_i && (!(is_read || is_write) || !qty_ok
                     || (is_write && !in_bank && config_write_lock_i));
        // Broadcasts never answer
        reply_nxt = (wr_go || rd_go) && !acc_broadcast_i
                    && !(wr_go && value_reg && !reply_after_value_write_i);

        fhm_nxt = mode == MODE_HIGH;
        flm_nxt = mode == MODE_LOW;
        // Other mode codes fall back to digits with range check
        ovh_nxt = !fhm_nxt && !flm_nxt && chk_high;
        ovl_nxt = !fhm_nxt && !flm_nxt && chk_low;
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            upper_r <= REG_RESET;
            lower_r <= REG_RESET;
            format_r <= REG_RESET;
            shift_r <= REG_RESET;
            shown_r <= VALUE_RESET;
            rd_data_r <= REG_RESET;
            rd_ack_r <= 1'b0;
            wr_ack_r <= 1'b0;
            reject_r <= 1'b0;
            reply_r <= 1'b0;
            ovh_r <= 1'b0;
            ovl_r <= 1'b0;
            fhm_r <= 1'b0;
            flm_r <= 1'b0;
        end else begin
            upper_r <= upper_nxt;
            lower_r <= lower_nxt;
            format_r <= format_nxt;
            shift_r <= shift_nxt;
            shown_r <= shown_nxt;
            rd_data_r <= rd_data_nxt;
            rd_ack_r <= rd_ack_nxt;
            wr_ack_r <= wr_ack_nxt;
            reject_r <= reject_nxt;
            reply_r <= reply_nxt;
            ovh_r <= ovh_nxt;
            ovl_r <= ovl_nxt;
            fhm_r <= fhm_nxt;
            flm_r <= flm_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Digit padding is done by the segment driver from min_digits_o
    assign rd_data_o = rd_data_r;
    assign rd_ack_o = rd_ack_r;
    assign wr_ack_o = wr_ack_r;
    assign reject_o = reject_r;
    assign reply_o = reply_r;
    assign shown_value_o = shown_r;
    assign over_range_high_warning_o = ovh_r;
    assign over_range_low_warning_o = ovl_r;
    assign fixed_high_message_o = fhm_r;
    assign fixed_low_message_o = flm_r;
    assign min_digits_o = format_r[MINDIG_HI:MINDIG_LO];
    assign dp_rightmost_o = format_r[DP_RIGHT_BIT];
    assign dp_places_o = format_r[DP_HI:DP_LO];
    assign left_shift_o = shift_r[SHIFT_HI:SHIFT_LO];

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence upper_write_s;
        wr_go && acc_idx_i == IDX_UPPER;
    endsequence

    sequence lower_write_s;
        wr_go && acc_idx_i == IDX_LOWER;
    endsequence

    sequence value_write_s;
        wr_go && value_reg;
    endsequence

    commit_pair_a: assert property (upper_write_s ##1 lower_write_s |=> shown_r == {$past(acc_data_i, 2), $past(acc_data_i)})
        else $error("Value pair did not commit");
    upper_hold_a: assert property (upper_write_s |=> $stable(shown_r))
        else $error("Upper write changed display");
    mode_high_a: assert property (format_r[MODE_HI:MODE_LO] == MODE_HIGH |=> fhm_r && !ovh_r && !ovl_r)
        else $error("High message missing");
    mode_low_a: assert property (format_r[MODE_HI:MODE_LO] == MODE_LOW |=> flm_r && !fhm_r)
        else $error("Low message missing");
    range_warn_a: assert property (format_r[MODE_HI:MODE_LO] == MODE_DIGITS |=> ovh_r == $past(chk_high) && ovl_r == $past(chk_low))
        else $error("Range warning wrong");
    reply_quiet_a: assert property (value_write_s and !reply_after_value_write_i |=> !reply_r && wr_ack_r)
        else $error("Reply after suppressed write");
    group_limit_a: assert property (acc_valid_i && acc_qty_i > GROUP_MAX |=> reject_r && !wr_ack_r && !rd_ack_r)
        else $error("Oversize group accepted");
    lock_free_a: assert property (lower_write_s and config_write_lock_i |=> wr_ack_r && !reject_r)
        else $error("Lock blocked value write");
    read_back_a: assert property (rd_go && acc_idx_i == IDX_FORMAT |=> rd_ack_r && rd_data_r == $past(format_r))
        else $error("Format read back wrong");

endmodule : dvr_display_value_register_bank

`default_nettype wire

// ### src/dvr_range_check.sv
`timescale 1ns/1ps
`default_nettype none

module dvr_range_check (
    input wire logic [31:0] value_i,
    input wire dvr_pkg::dvr_type_e type_i,
    output logic over_high_o,
    output logic over_low_o
);
    import dvr_pkg::*;

    logic signed [32:0] wide;

    // ************************************************************
    // Interpretation by value type
    // ************************************************************
    // 33 bits so a large unsigned 32-bit word never reads as negative
    always_comb begin
        unique case (type_i)
            TYPE_U16: wide = {17'h0_0000, value_i[15:0]};
            TYPE_S16: wide = {{17{value_i[15]}}, value_i[15:0]};
            TYPE_U32: wide = {1'b0, value_i};
            TYPE_S32: wide = {value_i[31], value_i};
        endcase
        over_high_o = wide > RANGE_MAX;
        over_low_o = wide < RANGE_MIN;
    end

endmodule : dvr_range_check

`default_nettype wire

// ### tb/dvr_display_value_register_bank_test.sv
`timescale 1ns/1ps
`default_nettype none

module dvr_display_value_register_bank_test;
    import dvr_pkg::*;
    logic sys_clk_i, rst_i, av, ab, lock, rflag;
    logic [7:0] af, aq;
    logic [15:0] ai, ad, rdat;
    logic rda, wra, rej, rep, over_range_high_warning, over_range_low_warning, fh, fl, dpr;
    logic [31:0] shown;
    logic [2:0] mind, dpp;
    logic [3:0] lsh;
    dvr_type_e vt;
    int bad_count, tests_run, cyc, i;
    logic [35:0] tbl [8];

    dvr_master_model m (.sys_clk_i(sys_clk_i), .rd_ack_i(rda), .wr_ack_i(wra), .reject_i(rej),
        .reply_i(rep), .rd_data_i(rdat), .acc_valid_o(av), .acc_func_o(af), .acc_idx_o(ai),
        .acc_qty_o(aq), .acc_data_o(ad), .acc_broadcast_o(ab));
    dvr_display_value_register_bank uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .acc_valid_i(av),
        .acc_func_i(af), .acc_idx_i(ai), .acc_qty_i(aq), .acc_data_i(ad), .acc_broadcast_i(ab),
        .value_type_i(vt), .config_write_lock_i(lock), .reply_after_value_write_i(rflag),
        .rd_data_o(rdat), .rd_ack_o(rda), .wr_ack_o(wra), .reject_o(rej), .reply_o(rep),
        .shown_value_o(shown), .over_range_high_warning_o(over_range_high_warning), .over_range_low_warning_o(over_range_low_warning),
        .fixed_high_message_o(fh), .fixed_low_message_o(fl), .min_digits_o(mind),
        .dp_rightmost_o(dpr), .dp_places_o(dpp), .left_shift_o(lsh));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [15:0] idx, input logic [15:0] dat);
        m.access(FN_WRITE_ONE, idx, 8'h01, dat, 1'b0, 1'b0);
    endtask : wr

    // Upper then lower in consecutive cycles, as one group frame
    task automatic wr_pair(input logic [15:0] up, input logic [15:0] lo);
        m.access(FN_WRITE_MANY, IDX_UPPER, 8'h02, up, 1'b0, 1'b1);
        m.access(FN_WRITE_MANY, IDX_LOWER, 8'h02, lo, 1'b0, 1'b0);
    endtask : wr_pair

    task automatic rd_chk(input logic [15:0] idx, input logic [15:0] exp);
        m.access(FN_READ, idx, 8'h01, 16'h0000, 1'b0, 1'b0);
        chk("read data", {16'h0000, m.rdat_r}, {16'h0000, exp});
        chk("read resp", {28'h0, m.resp_r}, 32'h9);
    endtask : rd_chk

    task print_verdict;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    // Hang guard, tests need well under a thousand cycles
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            print_verdict();
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        rst_i = 1'b1;
        m.init_bus();
        vt = TYPE_U32;
        lock = 1'b0;
        rflag = 1'b0;
        // Type, upper, lower, expected high and low warnings
        tbl = '{{2'h2, 32'h0000_270f, 2'b00}, {2'h2, 32'h0000_2710, 2'b10},
                {2'h3, 32'hffff_fc19, 2'b00}, {2'h3, 32'hffff_fc18, 2'b01},
                {2'h1, 32'h1234_fc18, 2'b01}, {2'h0, 32'h1234_fc18, 2'b10},
                {2'h0, 32'h1234_270f, 2'b00}, {2'h3, 32'h8000_0000, 2'b01}};
        repeat (3) @(posedge sys_clk_i);
        #1;
        rst_i = 1'b0;
        for (i = 1; i <= 4; i++) rd_chk(16'(i), REG_RESET);
        wr(IDX_UPPER, 16'habcd);
        chk("wr ack no reply", {28'h0, m.resp_r}, 32'h4);
        chk("upper alone", shown, VALUE_RESET);
        rd_chk(IDX_UPPER, 16'habcd);
        rflag = 1'b1;
        wr(IDX_LOWER, 16'h1234);
        chk("wr ack reply", {28'h0, m.resp_r}, 32'h5);
        chk("commit", shown, 32'habcd_1234);
        lock = 1'b1;
        for (i = 0; i < 8; i++) begin
            vt = dvr_type_e'(tbl[i][35:34]);
            wr_pair(tbl[i][33:18], tbl[i][17:2]);
            chk("lock free", {28'h0, m.resp_r}, 32'h5);
            repeat (3) @(posedge sys_clk_i);
            #1;
            chk("committed", shown, tbl[i][33:2]);
            chk("warnings", {30'h0, over_range_high_warning, over_range_low_warning}, {30'h0, tbl[i][1:0]});
        end
        wr(IDX_FORMAT, 16'h80da);
        repeat (2) @(posedge sys_clk_i);
        #1;
        chk("high msg", {30'h0, fh, fl}, 32'h2);
        chk("fields", {21'h0, mind, dpr, dpp, lsh}, {21'h0, 3'h5, 1'b1, 3'h2, 4'h0});
        rd_chk(IDX_FORMAT, 16'h80da);
        wr(IDX_FORMAT, 16'h4007);
        repeat (2) @(posedge sys_clk_i);
        #1;
        chk("low msg", {30'h0, fh, fl}, 32'h1);
        chk("dp places", {29'h0, dpp}, 32'h7);
        wr(IDX_FORMAT, 16'h0000);
        repeat (2) @(posedge sys_clk_i);
        #1;
        chk("digits mode", {28'h0, fh, fl, over_range_high_warning, over_range_low_warning}, 32'h1);
        wr(IDX_SHIFT, 16'hfff9);
        chk("shift", {28'h0, lsh}, 32'h9);
        m.access(8'h05, IDX_SHIFT, 8'h01, 16'h0001, 1'b0, 1'b0);
        chk("bad func", {28'h0, m.resp_r}, 32'h2);
        m.access(FN_WRITE_MANY, IDX_SHIFT, 8'h11, 16'h0001, 1'b0, 1'b0);
        chk("qty 17", {28'h0, m.resp_r}, 32'h2);
        m.access(FN_WRITE_MANY, IDX_SHIFT, GROUP_MAX, 16'h0003, 1'b0, 1'b0);
        chk("qty 16", {28'h0, lsh}, 32'h3);
        m.access(FN_WRITE_ONE, IDX_SHIFT, 8'h01, 16'h0005, 1'b1, 1'b0);
        chk("broadcast quiet", {28'h0, m.resp_r}, 32'h4);
        chk("broadcast shift", {28'h0, lsh}, 32'h5);
        m.access(FN_WRITE_ONE, 16'h0023, 8'h01, 16'h0001, 1'b0, 1'b0);
        chk("locked foreign", {28'h0, m.resp_r}, 32'h2);
        // Mid-run reset must clear the whole bank
        rst_i = 1'b1;
        repeat (3) @(posedge sys_clk_i);
        #1;
        rst_i = 1'b0;
        chk("reset value", shown, VALUE_RESET);
        chk("reset flags", {28'h0, fh, fl, over_range_high_warning, over_range_low_warning}, 32'h0);
        rd_chk(IDX_SHIFT, REG_RESET);
        rd_chk(IDX_UPPER, REG_RESET);
        print_verdict();
    end
endmodule : dvr_display_value_register_bank_test

`default_nettype wire

// ### tb/dvr_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module dvr_master_model (
    input wire logic sys_clk_i,
    input wire logic rd_ack_i,
    input wire logic wr_ack_i,
    input wire logic reject_i,
    input wire logic reply_i,
    input wire logic [15:0] rd_data_i,
    output logic acc_valid_o,
    output logic [7:0] acc_func_o,
    output logic [15:0] acc_idx_o,
    output logic [7:0] acc_qty_o,
    output logic [15:0] acc_data_o,
    output logic acc_broadcast_o
);
    // ************************************************************
    // One register access, answer taken one edge later
    // ************************************************************
    logic [3:0] resp_r;
    logic [15:0] rdat_r;

    // Called by the bench so one process drives the bus
    task automatic init_bus;
        acc_valid_o = 1'b0;
        acc_func_o = 8'h00;
        acc_idx_o = 16'h0000;
        acc_qty_o = 8'h01;
        acc_data_o = 16'h0000;
        acc_broadcast_o = 1'b0;
    endtask : init_bus

    task automatic access(input logic [7:0] fn, input logic [15:0] idx, input logic [7:0] qty,
                          input logic [15:0] dat, input logic bc, input logic hold);
        // A held request runs straight into the next, back to back
        if (!acc_valid_o) begin
            @(posedge sys_clk_i);
            #1;
        end
        acc_valid_o = 1'b1;
        acc_func_o = fn;
        acc_idx_o = idx;
        acc_qty_o = qty;
        acc_data_o = dat;
        acc_broadcast_o = bc;
        @(posedge sys_clk_i);
        #1;
        resp_r = {rd_ack_i, wr_ack_i, reject_i, reply_i};
        rdat_r = rd_data_i;
        if (!hold) begin
            acc_valid_o = 1'b0;
            // Released data shows no stale word
            acc_data_o = ~dat;
            acc_idx_o = ~idx;
        end
    endtask : access
endmodule : dvr_master_model

`default_nettype wire
